// ==== dv/main_module_model.sv ====
// Purpose: Main module: wakeup pin and UART receiver
// Assumes: 8N1 frames of BAUD core cycles a bit
// Notes: Counts frames and framing faults only
`timescale 1ns/10ps
module main_module_model #(
  parameter BAUD = 4
)(
  input wire core_clk,
  input wire uart_txd,
  output logic wakeup_pin
);
  int nbytes = 0;
  int nbad = 0;
  initial wakeup_pin = 1'b0;
  task automatic set_pin(input logic v);
    @(posedge core_clk);
    #10;
    wakeup_pin = v;
  endtask
  // Mid-bit sampling of start and stop
  always
  begin
    @(negedge uart_txd);
    repeat (BAUD / 2) @(posedge core_clk);
    if (uart_txd !== 1'b0)
      nbad++;
    repeat (9 * BAUD) @(posedge core_clk);
    if (uart_txd !== 1'b1)
      nbad++;
    nbytes++;
  end
endmodule

// ==== dv/snooze_data_logger_sequencer_bench.sv ====
// Purpose: Self-checking bench of the snooze sequencer
// Assumes: Short timer, alarm and baud counts
// Notes: Rows cover level judgment, then hand tests
`timescale 1ns/10ps
module snooze_data_logger_sequencer_bench;
  logic core_clk = 0, rst_b = 0, sleep_req = 0, sleep_wake_irq = 0, standby_req = 0;
  logic conv_trig_sel = 0, conv_done = 0, level_pin_clr = 0;
  logic [11:0] conv_ch0 = 0, conv_ch1 = 0, ch0_threshold = 0, ch1_threshold = 0;
  wire conv_start_ff, ch0_level_pin_ff, ch1_level_pin_ff, transfer_done_event_ff, uart_txd_ff;
  wire wakeup_pin, cpu_run, periph_run, osc_run;
  wire [1:0] power_mode_ff;
  int n_mismatch = 0, n_tests = 0, n = 0, cyc = 0;
  // ch0, thr0, ch1, thr1, ch0 pin, ch1 pin
  logic [49:0] rows [4] = '{{12'h7FF, 12'h800, 12'h7FF, 12'h800, 2'h0}, {12'h800, 12'h800, 12'h7FF, 12'h800, 2'h2},
    {12'h7FF, 12'h800, 12'h800, 12'h800, 2'h1}, {12'hFFF, 12'h000, 12'hFFF, 12'hFFE, 2'h3}};
  snooze_data_logger_sequencer #(.WAKE_CYCLES(200), .WAKES_PER_ALARM(3), .BAUD_CYCLES(4)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .wakeup_pin(wakeup_pin), .sleep_req(sleep_req),
    .sleep_wake_irq(sleep_wake_irq), .standby_req(standby_req), .conv_trig_sel(conv_trig_sel),
    .conv_done(conv_done), .conv_ch0(conv_ch0), .conv_ch1(conv_ch1), .ch0_threshold(ch0_threshold),
    .ch1_threshold(ch1_threshold), .level_pin_clr(level_pin_clr), .conv_start_ff(conv_start_ff),
    .ch0_level_pin_ff(ch0_level_pin_ff), .ch1_level_pin_ff(ch1_level_pin_ff),
    .transfer_done_event_ff(transfer_done_event_ff), .uart_txd_ff(uart_txd_ff), .power_mode_ff(power_mode_ff),
    .cpu_run(cpu_run), .periph_run(periph_run), .osc_run(osc_run));
  main_module_model #(.BAUD(4)) m (.core_clk(core_clk), .uart_txd(uart_txd_ff), .wakeup_pin(wakeup_pin));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results;
    end
  end
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge core_clk);
    #10;
  endtask
  function logic hit(input int w);
    case (w)
      0: return conv_start_ff;
      1: return transfer_done_event_ff;
      2: return power_mode_ff == 2'h0;
      3: return power_mode_ff == 2'h2;
      4: return m.nbytes == 12;
      default: return power_mode_ff != 2'h2;
    endcase
  endfunction
  task wait_for(input int w, input int lim);
    n = 0;
    do
    begin
      step(1);
      n++;
    end
    while (hit(w) !== 1'b1 && n < lim);
  endtask
  task start(input logic stby);
    rst_b = 0;
    step(4);
    rst_b = 1;
    standby_req = stby;
    step(1);
    standby_req = 0;
  endtask
  task snooze;
    wait_for(0, 1000);
    conv_done = 1;
    step(1);
    conv_done = 0;
    wait_for(1, 20);
    chk_val(n, 4);
    chk_val(power_mode_ff, 2'h2);
  endtask
  task results;
    $display("Counts: %0d mismatches in %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      conv_ch0 = rows[i][49:38];
      ch0_threshold = rows[i][37:26];
      conv_ch1 = rows[i][25:14];
      ch1_threshold = rows[i][13:2];
      conv_trig_sel = i[0];
      start(1);
      chk_val(power_mode_ff, 2'h2);
      snooze;
      chk_val(ch0_level_pin_ff, rows[i][1]);
      chk_val(ch1_level_pin_ff, rows[i][0]);
    end
    conv_trig_sel = 1;
    start(0);
    wait_for(0, 1000);
    wait_for(0, 1000);
    chk_val(n, 200);
    conv_trig_sel = 0;
    wait_for(0, 250);
    chk_val(n, 250);
    start(0);
    sleep_req = 1;
    step(1);
    sleep_req = 0;
    step(3);
    chk_val(power_mode_ff, 2'h1);
    sleep_wake_irq = 1;
    step(1);
    sleep_wake_irq = 0;
    chk_val(power_mode_ff, 2'h0);
    start(1);
    m.set_pin(1);
    wait_for(2, 10);
    chk_val(n <= 6, 1);
    wait_for(4, 1000);
    chk_val(m.nbad, 0);
    step(20);
    chk_val(m.nbytes, 12);
    chk_val(power_mode_ff, 2'h0);
    m.set_pin(0);
    wait_for(3, 20);
    chk_val(power_mode_ff, 2'h2);
    start(1);
    snooze;
    snooze;
    wait_for(5, 300);
    chk_val(power_mode_ff, 2'h0);
    level_pin_clr = 1;
    step(1);
    level_pin_clr = 0;
    chk_val({ch0_level_pin_ff, ch1_level_pin_ff}, 2'h0);
    wait_for(3, 100);
    chk_val(power_mode_ff, 2'h2);
    snooze;
    snooze;
    wait_for(5, 300);
    chk_val(power_mode_ff, 2'h0);
    results;
  end
endmodule
bind snooze_data_logger_sequencer snooze_seq_checker i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .wakeup_pin(wakeup_pin), .sleep_wake_irq(sleep_wake_irq), .conv_done(conv_done), .level_pin_clr(level_pin_clr),
  .conv_start_ff(conv_start_ff), .ch0_level_pin_ff(ch0_level_pin_ff), .ch1_level_pin_ff(ch1_level_pin_ff),
  .transfer_done_event_ff(transfer_done_event_ff), .power_mode_ff(power_mode_ff), .cpu_run(cpu_run),
  .periph_run(periph_run), .osc_run(osc_run));

// ==== dv/snooze_seq_checker_sva.sv ====
// Purpose: Port-level checks of the snooze sequencer
// Assumes: Synchronous active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/10ps
module snooze_seq_checker (
  input wire core_clk,
  input wire rst_b,
  input wire wakeup_pin,
  input wire sleep_wake_irq,
  input wire conv_done,
  input wire level_pin_clr,
  input wire conv_start_ff,
  input wire ch0_level_pin_ff,
  input wire ch1_level_pin_ff,
  input wire transfer_done_event_ff,
  input wire [1:0] power_mode_ff,
  input wire cpu_run,
  input wire periph_run,
  input wire osc_run
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_snooze_start: assert property (power_mode_ff == 2'h3 && $past(power_mode_ff) != 2'h3 |-> conv_start_ff)
    else $error("snooze entered without converter start");
  a_snooze_source: assert property ($rose(power_mode_ff == 2'h3) |-> $past(power_mode_ff) == 2'h2)
    else $error("snooze entered from a mode other than standby");
  a_done_pulse: assert property (transfer_done_event_ff |-> power_mode_ff == 2'h2 ##1 !transfer_done_event_ff)
    else $error("done event not a single pulse into standby");
  a_standby_stop: assert property (power_mode_ff == 2'h2 |-> !cpu_run && !osc_run)
    else $error("cpu or oscillator running in standby");
  a_sleep_state: assert property (power_mode_ff == 2'h1 |-> !cpu_run && periph_run && osc_run)
    else $error("wrong run flags in sleep");
  a_sleep_wake: assert property (power_mode_ff == 2'h1 && sleep_wake_irq |=> power_mode_ff == 2'h0)
    else $error("interrupt did not end sleep");
  a_low_after_fall: assert property ($rose(power_mode_ff == 2'h2) && $past(power_mode_ff) == 2'h0
    |-> !$past(wakeup_pin, 2))
    else $error("low power entered with wakeup pin high");
  a_ch1_cause: assert property ($rose(ch1_level_pin_ff) |-> $past(conv_done))
    else $error("ch1 pin rose without a conversion");
  a_ch0_cause: assert property ($rose(ch0_level_pin_ff) |-> transfer_done_event_ff)
    else $error("ch0 pin rose outside chain end");
  a_pin_sticky: assert property ($fell(ch0_level_pin_ff) || $fell(ch1_level_pin_ff) |-> $past(level_pin_clr))
    else $error("level pin fell without clear");
  a_start_pulse: assert property (conv_start_ff |=> !conv_start_ff)
    else $error("converter start longer than one cycle");
  c_done: cover property (transfer_done_event_ff);
  c_sleep: cover property (power_mode_ff == 2'h1 ##1 power_mode_ff == 2'h0);
  c_ch0: cover property ($rose(ch0_level_pin_ff));
endmodule

// ==== rtl/snooze_data_logger_sequencer.v ====
// Purpose: Operating mode sequencer of a low-power data logger
// Assumes: Converter results arrive on this clock; wakeup pin is asynchronous
// Notes: Processed values go out as twelve bytes, high byte first
// Contract
// - One-minute wake timer underflow requests Snooze from Software Standby.
// - Snooze converts two channels, started by a routed synchronous trigger.
// - Channel 0 judged by subtraction unit, channel 1 by window compare.
// - Result at or above threshold drives its level pin high.
// - Chained transfers: ch0 buffer, ch1 buffer, reference, subtraction input.
// - Channel 0 judgment drives ch0 pin; channel 1 match drives ch1 pin.
// - Transfer chain completion raises done event, returns to Software Standby.
// - Hourly alarm cancels low power and brings Normal mode.
// - Hourly wake reduces buffers to average, minimum, maximum into processed buffer.
// - Next alarm is armed before low power is re-entered.
// - Wakeup pin rising edge raises interrupt that cancels low power.
// - After wakeup request, transmit data is built and sent over UART.
// - Low power not re-entered until the wakeup pin has fallen.
// - Sleep halts CPU only; any interrupt or reset cancels it.
// - Software Standby stops CPU, peripherals, oscillators; retains state.
// - Snooze entered only from Software Standby; CPU stays halted.
// - Snooze interrupts can lead to Normal or back to Standby.
// - Event link routes snooze request or underflow to converter start.
// - Repeat mode moves one unit per activation, address wraps after size.
`timescale 1ns/10ps
`include "snooze_seq_defines.vh"

module snooze_data_logger_sequencer #(
  parameter DW = 12,
  parameter BUF_AW = 6,
  parameter WAKE_CYCLES = `SEQ_WAKE_CYCLES,
  parameter WAKES_PER_ALARM = `SEQ_WAKES_PER_ALARM,
  parameter BAUD_CYCLES = `SEQ_BAUD_CYCLES
)(
  input wire core_clk,
  input wire rst_b,
  input wire wakeup_pin,
  input wire sleep_req,
  input wire sleep_wake_irq,
  input wire standby_req,
  input wire conv_trig_sel,
  input wire conv_done,
  input wire [DW-1:0] conv_ch0,
  input wire [DW-1:0] conv_ch1,
  input wire [DW-1:0] ch0_threshold,
  input wire [DW-1:0] ch1_threshold,
  input wire level_pin_clr,
  output reg conv_start_ff,
  output reg ch0_level_pin_ff,
  output reg ch1_level_pin_ff,
  output reg transfer_done_event_ff,
  output reg uart_txd_ff,
  output reg [1:0] power_mode_ff,
  output wire cpu_run,
  output wire periph_run,
  output wire osc_run
);

  localparam [7:0] ST_NORMAL = 8'h01;
  localparam [7:0] ST_SLEEP = 8'h02;
  localparam [7:0] ST_STANDBY = 8'h04;
  localparam [7:0] ST_SNZ_CONV = 8'h08;
  localparam [7:0] ST_SNZ_XFER = 8'h10;
  localparam [7:0] ST_PROC = 8'h20;
  localparam [7:0] ST_TX = 8'h40;
  localparam [7:0] ST_WAIT_LOW = 8'h80;
  localparam DEPTH = 1 << BUF_AW;
  localparam SW = DW + BUF_AW;

  function [DW-1:0] fn_min;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      fn_min = (a < b) ? a : b;
    end
  endfunction

  function [DW-1:0] fn_max;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      fn_max = (a > b) ? a : b;
    end
  endfunction

  // Subtraction without borrow means result >= reference
  function fn_at_or_above;
    input [DW-1:0] val;
    input [DW-1:0] thr;
    reg [DW:0] diff;
    begin
      diff = {1'b0, val} - {1'b0, thr};
      fn_at_or_above = ~diff[DW];
    end
  endfunction

  reg [7:0] state_ff;
  reg [7:0] nxt_state;
  reg wk_meta_ff;
  reg wk_sync_ff;
  reg wk_prev_ff;
  reg [31:0] tmr_cnt_ff;
  reg [7:0] alarm_cnt_ff;
  reg alarm_armed_ff;
  reg alarm_pend_ff;
  reg wake_pend_ff;
  reg [DW-1:0] res0_ff;
  reg [DW-1:0] res1_ff;
  reg [DW-1:0] doc_ref_ff;
  reg [1:0] xfer_step_ff;
  reg [BUF_AW-1:0] wr_ptr_ff;
  reg [BUF_AW-1:0] rd_ptr_ff;
  reg [DW-1:0] buf0 [0:DEPTH-1];
  reg [DW-1:0] buf1 [0:DEPTH-1];
  reg [DW-1:0] proc_ff [0:5];
  reg [SW-1:0] sum0_ff;
  reg [SW-1:0] sum1_ff;
  reg [DW-1:0] min0_ff;
  reg [DW-1:0] min1_ff;
  reg [DW-1:0] max0_ff;
  reg [DW-1:0] max1_ff;
  reg [3:0] byte_idx_ff;
  reg [3:0] bit_idx_ff;
  reg [15:0] baud_cnt_ff;
  reg [9:0] tx_shift_ff;
  reg tx_busy_ff;

  wire tmr_uf = (tmr_cnt_ff == 32'h0);
  wire wk_rise = wk_sync_ff & ~wk_prev_ff;
  wire alarm_evt = tmr_uf & alarm_armed_ff & (alarm_cnt_ff == WAKES_PER_ALARM - 1);
  wire alarm_any = alarm_evt | alarm_pend_ff;
  wire wake_any = wk_rise | wake_pend_ff;
  wire snz_req = (state_ff == ST_STANDBY) & tmr_uf & ~alarm_any & ~wake_any;
  wire proc_last = (rd_ptr_ff == DEPTH - 1);
  wire [DW-1:0] rd0 = buf0[rd_ptr_ff];
  wire [DW-1:0] rd1 = buf1[rd_ptr_ff];
  wire [SW-1:0] sum0_n = sum0_ff + {{BUF_AW{1'b0}}, rd0};
  wire [SW-1:0] sum1_n = sum1_ff + {{BUF_AW{1'b0}}, rd1};
  wire [DW-1:0] tx_val = proc_ff[byte_idx_ff[3:1]];
  wire [15:0] tx_word = {{(16-DW){1'b0}}, tx_val};
  wire [7:0] tx_byte = byte_idx_ff[0] ? tx_word[7:0] : tx_word[15:8];
  wire baud_tick = (baud_cnt_ff == BAUD_CYCLES - 1);
  wire tx_frame_end = tx_busy_ff & baud_tick & (bit_idx_ff == 4'h9);
  wire tx_last = (byte_idx_ff == `SEQ_TX_BYTES - 4'h1);

  // Standby and snooze halt the CPU; standby also stops clocks
  assign cpu_run = (state_ff == ST_NORMAL) | (state_ff == ST_PROC) | (state_ff == ST_TX)
    | (state_ff == ST_WAIT_LOW);
  assign periph_run = ~(state_ff == ST_STANDBY);
  assign osc_run = ~(state_ff == ST_STANDBY);

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_NORMAL:
      begin
        if (alarm_any)
          nxt_state = ST_PROC;
        else if (wake_any)
          nxt_state = ST_TX;
        else if (sleep_req)
          nxt_state = ST_SLEEP;
        else if (standby_req)
          nxt_state = ST_STANDBY;
      end
      ST_SLEEP:
      begin
        if (sleep_wake_irq | alarm_any | wake_any)
          nxt_state = ST_NORMAL;
      end
      ST_STANDBY:
      begin
        if (alarm_any)
          nxt_state = ST_PROC;
        else if (wake_any)
          nxt_state = ST_TX;
        else if (snz_req)
          nxt_state = ST_SNZ_CONV;
      end
      ST_SNZ_CONV:
      begin
        if (alarm_any)
          nxt_state = ST_PROC;
        else if (wake_any)
          nxt_state = ST_TX;
        else if (conv_done)
          nxt_state = ST_SNZ_XFER;
      end
      ST_SNZ_XFER:
      begin
        if (xfer_step_ff == `SEQ_XFER_LAST)
          nxt_state = ST_STANDBY;
      end
      ST_PROC:
      begin
        if (proc_last)
          nxt_state = ST_STANDBY;
      end
      ST_TX:
      begin
        if (tx_frame_end & tx_last)
          nxt_state = ST_WAIT_LOW;
      end
      ST_WAIT_LOW:
      begin
        if (~wk_sync_ff)
          nxt_state = ST_STANDBY;
      end
      default:
        nxt_state = ST_NORMAL;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_NORMAL;
      power_mode_ff <= `SEQ_MODE_NORMAL;
      wk_meta_ff <= 1'b0;
      wk_sync_ff <= 1'b0;
      wk_prev_ff <= 1'b0;
      tmr_cnt_ff <= WAKE_CYCLES - 1;
      alarm_cnt_ff <= 8'h00;
      alarm_armed_ff <= 1'b1;
      alarm_pend_ff <= 1'b0;
      wake_pend_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (nxt_state == ST_SLEEP)
        power_mode_ff <= `SEQ_MODE_SLEEP;
      else if (nxt_state == ST_STANDBY)
        power_mode_ff <= `SEQ_MODE_STANDBY;
      else if ((nxt_state == ST_SNZ_CONV) | (nxt_state == ST_SNZ_XFER))
        power_mode_ff <= `SEQ_MODE_SNOOZE;
      else
        power_mode_ff <= `SEQ_MODE_NORMAL;
      wk_meta_ff <= wakeup_pin;
      wk_sync_ff <= wk_meta_ff;
      wk_prev_ff <= wk_sync_ff;
      tmr_cnt_ff <= tmr_uf ? WAKE_CYCLES - 1 : tmr_cnt_ff - 32'h1;
      if (alarm_evt)
      begin
        alarm_armed_ff <= 1'b0;
        alarm_cnt_ff <= 8'h00;
      end
      else if ((state_ff == ST_PROC) & proc_last)
      begin
        alarm_armed_ff <= 1'b1;
        alarm_cnt_ff <= 8'h00;
      end
      else if (tmr_uf)
        alarm_cnt_ff <= alarm_cnt_ff + 8'h01;
      // Pending flags: a new event wins over the clear
      if (alarm_evt)
        alarm_pend_ff <= 1'b1;
      else if (nxt_state == ST_PROC)
        alarm_pend_ff <= 1'b0;
      if (wk_rise)
        wake_pend_ff <= 1'b1;
      else if (nxt_state == ST_TX)
        wake_pend_ff <= 1'b0;
    end
  end

  // Snooze: conversion, chained transfers, judgments
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      conv_start_ff <= 1'b0;
      res0_ff <= {DW{1'b0}};
      res1_ff <= {DW{1'b0}};
      doc_ref_ff <= {DW{1'b0}};
      xfer_step_ff <= 2'h0;
      wr_ptr_ff <= {BUF_AW{1'b0}};
      ch0_level_pin_ff <= 1'b0;
      ch1_level_pin_ff <= 1'b0;
      transfer_done_event_ff <= 1'b0;
    end
    else
    begin
      conv_start_ff <= conv_trig_sel ? tmr_uf : snz_req;
      transfer_done_event_ff <= 1'b0;
      if ((state_ff == ST_SNZ_CONV) & conv_done)
      begin
        res0_ff <= conv_ch0;
        res1_ff <= conv_ch1;
        xfer_step_ff <= 2'h0;
        if (fn_at_or_above(conv_ch1, ch1_threshold))
          ch1_level_pin_ff <= 1'b1;
      end
      else if (state_ff == ST_SNZ_XFER)
      begin
        xfer_step_ff <= xfer_step_ff + 2'h1;
        case (xfer_step_ff)
          2'h0: buf0[wr_ptr_ff] <= res0_ff;
          2'h1:
          begin
            buf1[wr_ptr_ff] <= res1_ff;
            wr_ptr_ff <= wr_ptr_ff + {{(BUF_AW-1){1'b0}}, 1'b1};
          end
          2'h2: doc_ref_ff <= ch0_threshold;
          default:
          begin
            if (fn_at_or_above(res0_ff, doc_ref_ff))
              ch0_level_pin_ff <= 1'b1;
            transfer_done_event_ff <= 1'b1;
          end
        endcase
      end
      else if (level_pin_clr & cpu_run)
      begin
        ch0_level_pin_ff <= 1'b0;
        ch1_level_pin_ff <= 1'b0;
      end
    end
  end

  // Hourly reduction of both buffers
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rd_ptr_ff <= {BUF_AW{1'b0}};
      sum0_ff <= {SW{1'b0}};
      sum1_ff <= {SW{1'b0}};
      min0_ff <= {DW{1'b1}};
      min1_ff <= {DW{1'b1}};
      max0_ff <= {DW{1'b0}};
      max1_ff <= {DW{1'b0}};
    end
    else if (state_ff == ST_PROC)
    begin
      rd_ptr_ff <= rd_ptr_ff + {{(BUF_AW-1){1'b0}}, 1'b1};
      sum0_ff <= sum0_n;
      sum1_ff <= sum1_n;
      min0_ff <= fn_min(min0_ff, rd0);
      min1_ff <= fn_min(min1_ff, rd1);
      max0_ff <= fn_max(max0_ff, rd0);
      max1_ff <= fn_max(max1_ff, rd1);
      if (proc_last)
      begin
        proc_ff[0] <= sum0_n[SW-1:BUF_AW];
        proc_ff[1] <= fn_min(min0_ff, rd0);
        proc_ff[2] <= fn_max(max0_ff, rd0);
        proc_ff[3] <= sum1_n[SW-1:BUF_AW];
        proc_ff[4] <= fn_min(min1_ff, rd1);
        proc_ff[5] <= fn_max(max1_ff, rd1);
      end
    end
    else
    begin
      rd_ptr_ff <= {BUF_AW{1'b0}};
      sum0_ff <= {SW{1'b0}};
      sum1_ff <= {SW{1'b0}};
      min0_ff <= {DW{1'b1}};
      min1_ff <= {DW{1'b1}};
      max0_ff <= {DW{1'b0}};
      max1_ff <= {DW{1'b0}};
    end
  end

  // UART transmit, 8N1, LSB first
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      uart_txd_ff <= 1'b1;
      tx_busy_ff <= 1'b0;
      byte_idx_ff <= 4'h0;
      bit_idx_ff <= 4'h0;
      baud_cnt_ff <= 16'h0000;
      tx_shift_ff <= 10'h3FF;
    end
    else if (state_ff != ST_TX)
    begin
      uart_txd_ff <= 1'b1;
      tx_busy_ff <= 1'b0;
      byte_idx_ff <= 4'h0;
      bit_idx_ff <= 4'h0;
      baud_cnt_ff <= 16'h0000;
    end
    else if (!tx_busy_ff)
    begin
      tx_shift_ff <= {1'b1, tx_byte, 1'b0};
      tx_busy_ff <= 1'b1;
      bit_idx_ff <= 4'h0;
      baud_cnt_ff <= 16'h0000;
      uart_txd_ff <= 1'b0;
    end
    else if (baud_tick)
    begin
      baud_cnt_ff <= 16'h0000;
      if (bit_idx_ff == 4'h9)
      begin
        tx_busy_ff <= 1'b0;
        byte_idx_ff <= byte_idx_ff + 4'h1;
      end
      else
      begin
        bit_idx_ff <= bit_idx_ff + 4'h1;
        tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
        uart_txd_ff <= tx_shift_ff[1];
      end
    end
    else
      baud_cnt_ff <= baud_cnt_ff + 16'h0001;
  end

endmodule

// ==== rtl/snooze_seq_defines.vh ====
// Purpose: Constants for the snooze data logger sequencer
// Assumes: core clock of 10 MHz
// Notes: Timing counts are derived from the times below
`ifndef SNOOZE_SEQ_DEFINES_VH
`define SNOOZE_SEQ_DEFINES_VH

`define SEQ_CLK_HZ 10000000
`define SEQ_WAKE_PERIOD_S 60
`define SEQ_WAKE_CYCLES (`SEQ_WAKE_PERIOD_S * `SEQ_CLK_HZ)
`define SEQ_WAKES_PER_ALARM 60
`define SEQ_BAUD 9600
`define SEQ_BAUD_CYCLES (`SEQ_CLK_HZ / `SEQ_BAUD)
`define SEQ_XFER_LAST 2'h3
`define SEQ_TX_BYTES 4'hC
`define SEQ_MODE_NORMAL 2'h0
`define SEQ_MODE_SLEEP 2'h1
`define SEQ_MODE_STANDBY 2'h2
`define SEQ_MODE_SNOOZE 2'h3

`endif
